// file: rtl/line_fifo.sv
// Synchronous FIFO carrying line samples toward the host.
// Assumes one clock; both sides use valid/ready.
`timescale 1ns/1ps
module line_fifo #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_q;
	logic [AW-1:0]    rd_q;
	logic [AW:0]      cnt_q;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_q  <= '0;
			rd_q  <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				mem_q[wr_q] <= in_data;
				wr_q        <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

endmodule : line_fifo

// file: rtl/sensor_drive.sv
// Drive-timing and acquisition controller for a linear image sensor.
// Assumes a 10 MHz clock, trigger input synchronous to it, and a
// register port with read data one cycle after the read strobe.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Four trigger modes steer acquisition
// - Six-bit gain code held
// - Gain code resets to zero
// - Nine-bit sign-magnitude offset code held
// - Of the timings, only pulse width and period programmable
// - Integration equals width plus 48 clocks
// - Period exceeds pulse width except in level mode
// - Drive intervals 4, 52, 87 clocks
// - Internal mode starts on Start command
// - Edge mode starts on trigger edges
// - Edge triggers before Start pulse, data not forwarded
// - Period upper limit in internal, gate
// - Period range 2500 to 4294967295
// - Width at least 10, period minus 200
module sensor_drive
	import sensor_drive_pkg::*;
#(
	parameter int unsigned SAMPLE_W = 16,
	parameter int unsigned FIFO_D   = 8
) (
	input  wire logic                clk,
	input  wire logic                rst,
	input  wire logic [3:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_write,
	input  wire logic                reg_read,
	output logic      [31:0]         reg_rdata,
	input  wire logic                ext_trigger,
	input  wire logic [SAMPLE_W-1:0] adc_sample,
	output logic                     integration_pulse,
	output logic                     drive_interval_one,
	output logic                     drive_interval_two,
	output logic                     drive_interval_three,
	output logic                     sample_strobe,
	output logic [5:0]               gain_code,
	output logic [8:0]               offset_code,
	output logic [31:0]              integration_cycles,
	output logic [SAMPLE_W-1:0]      host_data,
	output logic                     host_valid,
	input  wire logic                host_ready,
	output logic                     overflow
);
	import sensor_drive_pkg::*;

	typedef struct packed {
		trig_mode_t  mode;
		logic        armed;
		logic        running;
		logic        forward;
		logic        trig_prev;
		logic [5:0]  gain;
		logic [8:0]  offset;
		logic [31:0] width;
		logic [31:0] period;
		logic [31:0] cnt;
		logic        pulse;
		logic        ovf;
		logic [31:0] lines;
		logic [31:0] rdata;
	} state_t;

	state_t s_q;
	state_t s_d;

	logic                fifo_in_ready;
	logic [SAMPLE_W-1:0] fifo_out;
	logic                fifo_out_valid;
	logic                pop;
	logic                trig_rise;
	logic                fire;
	logic                period_done;
	logic                gated;
	logic [31:0]         w_lim;
	logic [31:0]         w_eff;
	logic                in_window;

	////////////////////////////////////////////////////////////////////////////
	// Line buffer toward the host
	assign pop = reg_read && reg_addr == ADDR_DATA;

	line_fifo #(
		.WIDTH (SAMPLE_W),
		.DEPTH (FIFO_D)
	) u_fifo (
		.clk       (clk),
		.rst       (rst),
		.in_data   (adc_sample),
		.in_valid  (sample_strobe & s_q.forward),
		.in_ready  (fifo_in_ready),
		.out_data  (fifo_out),
		.out_valid (fifo_out_valid),
		.out_ready (host_ready | pop)
	);

	////////////////////////////////////////////////////////////////////////////
	// Derived timing
	assign trig_rise   = ext_trigger & ~s_q.trig_prev;
	assign gated       = (s_q.mode == MODE_LEVEL) || (s_q.mode == MODE_GATE);
	// Limit the width to period-200 so the pulse ends before the period, except in level mode
	assign w_lim       = (s_q.period > WIDTH_MARGIN) ? s_q.period - WIDTH_MARGIN : WIDTH_MIN;
	assign w_eff       = (s_q.mode != MODE_LEVEL && s_q.width > w_lim) ? w_lim : s_q.width;
	assign period_done = (s_q.cnt >= s_q.period - 32'h1);
	assign in_window   = s_q.pulse || s_q.cnt != '0;

	always_comb begin
		fire = 1'b0;
		case (s_q.mode)
			MODE_INTERNAL: fire = s_q.running && (!in_window || period_done);
			MODE_EDGE:     fire = trig_rise;
			MODE_LEVEL:    fire = ext_trigger && !in_window;
			MODE_GATE:     fire = ext_trigger && (!in_window || period_done);
			default:       fire = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Next-state logic
	always_comb begin
		s_d           = s_q;
		s_d.trig_prev = ext_trigger;
		s_d.rdata     = '0;

		if (fire) begin
			s_d.cnt     = '0;
			s_d.pulse   = 1'b1;
			// Edge-mode data only after Start
			s_d.forward = (s_q.mode == MODE_EDGE) ? s_q.armed : 1'b1;
			if (s_d.forward) begin
				s_d.lines = s_q.lines + 32'h1;
			end
		end else if (in_window) begin
			s_d.cnt = s_q.cnt + 32'h1;
			if (s_q.pulse && s_q.cnt >= w_eff - 32'h1) begin
				s_d.pulse = 1'b0;
			end
			if (gated && !ext_trigger && s_q.pulse) begin
				s_d.pulse = 1'b0;
			end
			if (s_q.mode != MODE_EDGE && period_done) begin
				s_d.cnt = '0;
			end
			if (s_q.cnt == 32'hFFFF_FFFE) begin
				s_d.cnt = '0;
			end
		end

		if (sample_strobe && s_q.forward && !fifo_in_ready) begin
			s_d.ovf = 1'b1;
		end

		if (reg_write) begin
			case (reg_addr)
				ADDR_CTRL: begin
					s_d.mode = trig_mode_t'(reg_wdata[CTRL_MODE_LSB +: 2]);
					// Edge lines never close by period; leaving edge mode closes them
					if (s_q.mode == MODE_EDGE && s_d.mode != MODE_EDGE) begin
						s_d.cnt   = '0;
						s_d.pulse = 1'b0;
					end
					if (reg_wdata[CTRL_START_BIT]) begin
						s_d.armed   = 1'b1;
						s_d.running = 1'b1;
					end
					if (reg_wdata[CTRL_STOP_BIT]) begin
						s_d.armed   = 1'b0;
						s_d.running = 1'b0;
						s_d.forward = 1'b0;
					end
				end
				ADDR_GAIN:   s_d.gain = reg_wdata[5:0];
				ADDR_OFFSET: s_d.offset = reg_wdata[8:0];
				ADDR_WIDTH: begin
					s_d.width = (reg_wdata < WIDTH_MIN) ? WIDTH_MIN : reg_wdata;
				end
				ADDR_PERIOD: begin
					s_d.period = (reg_wdata < PERIOD_MIN) ? PERIOD_MIN : reg_wdata;
				end
				ADDR_STATUS: begin
					if (reg_wdata[0] && !(sample_strobe && s_q.forward && !fifo_in_ready)) begin
						s_d.ovf = 1'b0;
					end
				end
				default: ;
			endcase
		end

		if (reg_read) begin
			case (reg_addr)
				ADDR_CTRL:   s_d.rdata = {28'h0, s_q.running, 1'b0, 2'(s_q.mode)};
				ADDR_GAIN:   s_d.rdata = {26'h0, s_q.gain};
				ADDR_OFFSET: s_d.rdata = {23'h0, s_q.offset};
				ADDR_WIDTH:  s_d.rdata = s_q.width;
				ADDR_PERIOD: s_d.rdata = s_q.period;
				ADDR_STATUS: s_d.rdata = {28'h0, fifo_out_valid, s_q.forward, s_q.pulse, s_q.ovf};
				ADDR_LINES:  s_d.rdata = s_q.lines;
				ADDR_DATA:   s_d.rdata = {{(32-SAMPLE_W){1'b0}}, fifo_out};
				default:     s_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s_q        <= '0;
			s_q.mode   <= MODE_INTERNAL;
			s_q.gain   <= GAIN_RESET;
			s_q.offset <= OFFSET_RESET;
			s_q.width  <= WIDTH_RESET;
			s_q.period <= PERIOD_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs; drive intervals counted from the pulse rising edge
	assign integration_pulse    = s_q.pulse;
	assign drive_interval_one   = in_window && s_q.cnt < 32'(DRIVE_ONE_CYC);
	assign drive_interval_two   = in_window && s_q.cnt < 32'(DRIVE_TWO_CYC);
	assign drive_interval_three = in_window && s_q.cnt < 32'(DRIVE_THREE_CYC);
	assign sample_strobe        = in_window && !s_q.pulse;
	assign gain_code            = s_q.gain;
	assign offset_code          = s_q.offset;
	assign integration_cycles   = w_eff + 32'(INTEG_EXTRA_CYC);
	assign host_data            = fifo_out;
	assign host_valid           = fifo_out_valid;
	assign overflow             = s_q.ovf;
	assign reg_rdata            = s_q.rdata;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence pulse_rise;
		!integration_pulse ##1 integration_pulse;
	endsequence

	sequence interval_two_end;
		drive_interval_two ##1 !drive_interval_two;
	endsequence

	sequence interval_three_end;
		drive_interval_three ##1 !drive_interval_three;
	endsequence

	a_gain_after_reset: assert property ($fell(rst) |-> gain_code == 6'h00)
		else $error("gain not zero after reset");
	a_width_below_period: assert property (s_q.mode != MODE_LEVEL |-> w_eff < s_q.period)
		else $error("pulse width not below period");
	a_width_floor: assert property (s_q.width >= WIDTH_MIN)
		else $error("width below floor");
	a_period_floor: assert property (s_q.period >= PERIOD_MIN)
		else $error("period below floor");
	a_counter_start: assert property (pulse_rise |-> s_q.cnt == 32'h0)
		else $error("counter not cleared at pulse rise");
	a_interval_one: assert property (pulse_rise |-> drive_interval_one [*4] ##1 !drive_interval_one)
		else $error("first drive interval length wrong");
	a_edge_ignored: assert property ((s_q.mode == MODE_EDGE && !s_q.armed && fire) |=> !s_q.forward)
		else $error("early edge trigger forwarded");
	a_gate_held: assert property ((gated && !ext_trigger && s_q.pulse) |=> !integration_pulse)
		else $error("pulse while trigger inactive");
	a_integ_time: assert property (($fell(integration_pulse) && !gated && !$past(reg_write)
		&& !$past(reg_write, 2)) |-> s_q.cnt + 32'(INTEG_EXTRA_CYC) == integration_cycles)
		else $error("integration time mismatch");
	a_internal_idle: assert property ((s_q.mode == MODE_INTERNAL && !s_q.running && !in_window) |=> !integration_pulse)
		else $error("internal pulse without Start");
	a_interval_two: assert property (pulse_rise |-> ##51 interval_two_end)
		else $error("second drive interval length wrong");
	a_interval_three: assert property (pulse_rise |-> ##86 interval_three_end)
		else $error("third drive interval length wrong");
	a_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
		else $error("read data outside read slot");
	a_ovf_set: assert property ((sample_strobe && s_q.forward && !fifo_in_ready) |=> overflow)
		else $error("overflow not raised");
	a_ovf_sticky: assert property ((overflow && !(reg_write && reg_addr == ADDR_STATUS
		&& reg_wdata[0])) |=> overflow)
		else $error("overflow dropped without clear");
	a_stop_halts: assert property ((reg_write && reg_addr == ADDR_CTRL
		&& reg_wdata[CTRL_STOP_BIT]) |=> !s_q.running && !s_q.forward)
		else $error("stop left acquisition running");
	a_edge_forward: assert property ((s_q.mode == MODE_EDGE && s_q.armed && fire
		&& !reg_write) |=> s_q.forward)
		else $error("armed edge trigger not forwarded");
	a_edge_refire: assert property ((s_q.mode == MODE_EDGE && trig_rise && !reg_write)
		|=> integration_pulse && s_q.cnt == 32'h0)
		else $error("edge trigger did not restart line");
	a_internal_period: assert property ((s_q.mode == MODE_INTERNAL && s_q.running
		&& period_done && !reg_write) |=> integration_pulse && s_q.cnt == 32'h0)
		else $error("internal line did not repeat");
	a_gain_write: assert property ((reg_write && reg_addr == ADDR_GAIN)
		|=> {26'h0, gain_code} == ($past(reg_wdata) & 32'h0000_003F))
		else $error("gain code not taken");
	a_offset_write: assert property ((reg_write && reg_addr == ADDR_OFFSET)
		|=> {23'h0, offset_code} == ($past(reg_wdata) & 32'h0000_01FF))
		else $error("offset code not taken");
	a_level_idle: assert property ((s_q.mode == MODE_LEVEL && !ext_trigger && !in_window)
		|=> !integration_pulse)
		else $error("level pulse without trigger");
	a_gate_idle: assert property ((s_q.mode == MODE_GATE && !ext_trigger && !in_window)
		|=> !integration_pulse)
		else $error("gate pulse without trigger");
	a_lines_step: assert property ((fire && s_q.mode != MODE_EDGE && !reg_write)
		|=> s_q.lines == $past(s_q.lines) + 32'h1)
		else $error("line count not advanced");

endmodule : sensor_drive

// file: rtl/sensor_drive_pkg.sv
// Constants for the linear sensor drive-timing controller.
// Assumes a single 10 MHz clock and synchronous active-high reset.
package sensor_drive_pkg;

	localparam int unsigned CLK_PERIOD_NS     = 100;
	localparam int unsigned DRIVE_ONE_NS      = 400;
	localparam int unsigned DRIVE_TWO_NS      = 5200;
	localparam int unsigned DRIVE_THREE_NS    = 8700;
	localparam int unsigned DRIVE_ONE_CYC     = (DRIVE_ONE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DRIVE_TWO_CYC     = (DRIVE_TWO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DRIVE_THREE_CYC   = (DRIVE_THREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned INTEG_EXTRA_CYC   = 48;

	localparam logic [31:0] PERIOD_MIN        = 32'h0000_09C4;
	localparam logic [31:0] PERIOD_MAX        = 32'hFFFF_FFFF;
	localparam logic [31:0] WIDTH_MIN         = 32'h0000_000A;
	localparam logic [31:0] WIDTH_MARGIN      = 32'h0000_00C8;

	localparam logic [3:0]  ADDR_CTRL         = 4'h0;
	localparam logic [3:0]  ADDR_GAIN         = 4'h1;
	localparam logic [3:0]  ADDR_OFFSET       = 4'h2;
	localparam logic [3:0]  ADDR_WIDTH        = 4'h3;
	localparam logic [3:0]  ADDR_PERIOD       = 4'h4;
	localparam logic [3:0]  ADDR_STATUS       = 4'h5;
	localparam logic [3:0]  ADDR_LINES        = 4'h6;
	localparam logic [3:0]  ADDR_DATA         = 4'h7;

	localparam int unsigned CTRL_MODE_LSB     = 0;
	localparam int unsigned CTRL_START_BIT    = 2;
	localparam int unsigned CTRL_STOP_BIT     = 3;

	localparam logic [5:0]  GAIN_RESET        = 6'h00;
	localparam logic [8:0]  OFFSET_RESET      = 9'h000;
	localparam logic [31:0] WIDTH_RESET       = 32'h0000_0064;
	localparam logic [31:0] PERIOD_RESET      = 32'h0000_09C4;

	typedef enum logic [1:0] {
		MODE_INTERNAL,
		MODE_EDGE,
		MODE_LEVEL,
		MODE_GATE
	} trig_mode_t;

endpackage : sensor_drive_pkg

// file: sim/sensor_model.sv
// Behavioural sensor and trigger source at the far side of the drive.
// Assumes the bench requests trigger levels; samples follow the strobe.
`timescale 1ns/1ps
module sensor_model (
	input  wire logic        clk,
	input  wire logic        sample_strobe,
	input  wire logic        trig_req,
	output logic             ext_trigger,
	output logic [15:0]      adc_sample
);
	logic [15:0] pix_q = 16'h0000;
	initial ext_trigger = 1'b0;
	always @(posedge clk) begin
		ext_trigger <= trig_req;
		if (sample_strobe) begin
			pix_q <= pix_q + 16'h0001;
		end
	end
	// Outside the readout window the video line is not held
	assign adc_sample = sample_strobe ? pix_q : ~pix_q;
endmodule : sensor_model

// file: sim/tb_sensor_drive.sv
// Self-checking bench for the sensor drive controller.
// Assumes sensor_model on the far side and one 10 MHz clock.
`timescale 1ns/1ps
module tb_sensor_drive;
	import sensor_drive_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_write = 1'b0;
	logic        reg_read = 1'b0;
	logic        trig_req = 1'b0;
	logic        host_ready = 1'b0;
	logic        ext_trigger, integration_pulse, host_valid, overflow, sample_strobe;
	logic        drive_interval_one, drive_interval_two, drive_interval_three;
	logic [15:0] adc_sample, host_data;
	logic [5:0]  gain_code;
	logic [8:0]  offset_code;
	logic [31:0] reg_rdata, integration_cycles, rd;
	int          failures = 0, cmp_count = 0, cycles = 0, rises = 0;
	int          run_len [5], last_len [5], per_cnt = 0, per_last = 0;
	wire  [4:0]  drv = {sample_strobe, drive_interval_three, drive_interval_two,
		drive_interval_one, integration_pulse};
	localparam logic [31:0] FIFO_DEPTH_EXP = 32'd8;

	sensor_drive u_sensor_drive (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .ext_trigger(ext_trigger), .adc_sample(adc_sample),
		.integration_pulse(integration_pulse), .drive_interval_one(drive_interval_one),
		.drive_interval_two(drive_interval_two),
		.drive_interval_three(drive_interval_three), .sample_strobe(sample_strobe),
		.gain_code(gain_code), .offset_code(offset_code),
		.integration_cycles(integration_cycles), .host_data(host_data),
		.host_valid(host_valid), .host_ready(host_ready), .overflow(overflow));
	sensor_model u_sensor_model (.clk(clk), .sample_strobe(sample_strobe),
		.trig_req(trig_req), .ext_trigger(ext_trigger), .adc_sample(adc_sample));

	initial forever #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////
	// Run lengths of pulse and intervals, rise-to-rise period, timeout
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			failures = failures + 1;
			test_done();
		end
		per_cnt <= per_cnt + 1;
		if (integration_pulse === 1'b1 && run_len[0] == 0) begin
			rises <= rises + 1;
			per_last <= per_cnt;
			per_cnt <= 1;
		end
		for (int i = 0; i < 5; i++) begin
			if (drv[i] === 1'b1) begin
				run_len[i] <= run_len[i] + 1;
			end else if (run_len[i] != 0) begin
				last_len[i] <= run_len[i];
				run_len[i] <= 0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clk);
		reg_write <= 1'b0;
	endtask : wr
	task automatic rdr(input logic [3:0] a);
		@(posedge clk);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clk);
		reg_read <= 1'b0;
		#1 rd = reg_rdata;
	endtask : rdr
	task automatic wait_cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : wait_cyc
	task automatic trig(input int n);
		@(posedge clk);
		trig_req <= 1'b1;
		repeat (n) @(posedge clk);
		trig_req <= 1'b0;
	endtask : trig

	////////////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		wait_cyc(1);
		check("gain rst", {26'h0, gain_code}, 32'h0);
		check("integ rst", integration_cycles, WIDTH_RESET + 32'd48);
		wr(ADDR_GAIN, 32'h3F);
		rdr(ADDR_GAIN);
		check("gain", {26'h0, gain_code}, 32'h3F);
		check("gain rd", rd, 32'h3F);
		wr(ADDR_OFFSET, 32'h1FF);
		rdr(ADDR_OFFSET);
		check("offset", {23'h0, offset_code}, 32'h1FF);
		check("offset rd", rd, 32'h1FF);
		wr(ADDR_WIDTH, 32'h5);
		rdr(ADDR_WIDTH);
		check("width floor", rd, 32'hA);
		wr(ADDR_PERIOD, 32'h64);
		rdr(ADDR_PERIOD);
		check("period floor", rd, 32'h9C4);
		wr(ADDR_WIDTH, 32'hBB8);
		wait_cyc(2);
		check("width cap", integration_cycles, 32'h92C);
		rdr(4'h9);
		check("unmapped", rd, 32'h0);
	endtask : t_regs
	task automatic t_internal();
		int n;
		wr(ADDR_WIDTH, 32'h14);
		wr(ADDR_CTRL, 32'h4);
		wait_cyc(5200);
		check("period", per_last, 32'd2500);
		check("pulse", last_len[0], 32'd20);
		check("t1", last_len[1], 32'd4);
		check("t2", last_len[2], 32'd52);
		check("t3", last_len[3], 32'd87);
		check("integ", integration_cycles, 32'd68);
		check("strobe", last_len[4], 32'd2480);
		rdr(ADDR_STATUS);
		check("ovf", {31'h0, rd[0]}, 32'h1);
		wr(ADDR_CTRL, 32'h8);
		wait_cyc(2600);
		wr(ADDR_STATUS, 32'h1);
		wait_cyc(2);
		check("ovf clr", {31'h0, overflow}, 32'h0);
		n = 0;
		@(posedge clk);
		host_ready <= 1'b1;
		repeat (12) begin
			@(posedge clk);
			if (host_valid === 1'b1) begin
				check("host data", {16'h0, host_data}, 32'(n));
				n++;
			end
		end
		check("drained", n, FIFO_DEPTH_EXP);
	endtask : t_internal
	task automatic t_trig();
		int r0;
		logic [31:0] l0;
		wr(ADDR_CTRL, 32'h1);
		rdr(ADDR_LINES);
		l0 = rd;
		r0 = rises;
		trig(3);
		wait_cyc(2600);
		check("edge early", rises - r0, 32'd1);
		rdr(ADDR_LINES);
		check("lines early", rd, l0);
		wr(ADDR_CTRL, 32'h5);
		trig(3);
		wait_cyc(2600);
		check("edge pulses", rises - r0, 32'd2);
		rdr(ADDR_LINES);
		check("lines", rd, l0 + 32'd1);
		wr(ADDR_CTRL, 32'h6);
		r0 = rises;
		trig(5);
		wait_cyc(30);
		check("level", last_len[0], 32'd5);
		wr(ADDR_CTRL, 32'h7);
		wait_cyc(2600);
		check("gate idle", rises - r0, 32'd1);
		trig(2700);
		check("gate run", {31'h0, rises > r0 + 1}, 32'h1);
	endtask : t_trig

	task automatic test_done();
		if (failures == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : test_done

	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_regs();
		t_internal();
		t_trig();
		test_done();
	end
endmodule : tb_sensor_drive
